// *** vector_move_pipeline.sv ***
// vector move pipeline: sequencer, element datapath and register slave
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "vector_move_defines.svh"
module vector_move_pipeline (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic reqValid,
    input wire vector_move_pkg::op_t reqOp,
    input wire logic [6:0] reqCount,
    input wire logic reqMasked,
    input wire logic reqBroadcast,
    input wire logic reqStrideOne,
    input wire logic [`VM_WORD_W-1:0] thirdRegData,
    input wire logic [63:0] maskBits,
    input wire logic suspend,
    input wire logic [`VM_ELEM_W-1:0] srcData,
    input wire logic [`VM_ELEM_W-1:0] shadowData,
    output logic reqAck,
    output logic busy,
    output logic done,
    output logic [5:0] srcRdIdx,
    output logic dstWe,
    output logic [5:0] dstIdx,
    output logic [`VM_ELEM_W-1:0] dstData,
    output logic addValid,
    output logic [`VM_ELEM_W-1:0] addData
);
    import vector_move_pkg::*;

    state_t state_q, state_d;
    op_t op_q, op_d;
    logic [6:0] cnt_q, cnt_d, elem_q, elem_d, out_q, out_d, wcnt_q, wcnt_d;
    logic masked_q, masked_d, bcast_q, bcast_d;
    logic [`VM_WORD_W-1:0] gen_q, gen_d, stride_q, stride_d;
    logic pend_q, pend_d, ack_q, ack_d, done_q, done_d, busy_q, busy_d;
    logic [5:0] pendIdx_q, pendIdx_d, dstIdx_q, dstIdx_d;
    logic [4:0] pendSlot_q, pendSlot_d;
    logic dstWe_q, dstWe_d, addValid_q, addValid_d;
    logic [`VM_ELEM_W-1:0] dstData_q, dstData_d, addData_q, addData_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic issue, sel, maskBit, lastElem, isCompress, isDist, isDouble, bufWe;
    logic [`VM_ELEM_W-1:0] src, item, bufRd;
    logic [6:0] cntEff;

    ////////////////////////////////////////////////////////////////////////
    // element datapath

    assign maskBit = maskBits[elem_q[5:0]];
    assign isCompress = op_q == compress_op || op_q == double_compress_op;
    assign isDist = op_q == distribute_op || op_q == double_distribute_op;
    assign isDouble = !op_q[3] && op_q[0];
    // suspension only stalls issue; the element counter holds its place
    assign issue = state_q == ST_RUN && !suspend;
    assign lastElem = elem_q == cnt_q - 7'h1;

    // select, source and item for the element at elem_q
    always_comb begin
        src = bcast_q ? {thirdRegData, thirdRegData} : srcData;
        if (isCompress) begin
            sel = maskBit == ctrl_q[`VM_CTRL_POLARITY];
        end else if (isDist || masked_q) begin
            sel = maskBit;
        end else begin
            sel = 1'b1;
        end
        case (op_q)
            move_negated_op: item = {36'h0, ~src[35:0]};
            double_move_negated_op: item = ~src;
            index_generate_op: item = {36'h0, gen_q};
            population_parity_op: item = {71'h0, ^src[35:0]};
            single_to_double_convert_op: item = shadowData;
            double_to_single_convert_op: item = {36'h0, shadowData[35:0]};
            sign_count_op: item = shadowData;
            default: item = isDouble ? src : {36'h0, src[35:0]};
        endcase
    end

    assign bufWe = issue && sel;

    // every selected element lands in the move buffer before the destination file
    move_buffer move_buffer_inst (
        .clk(clk),
        .reset(reset),
        .wrEn(bufWe),
        .wrSlot(elem_q[4:0]),
        .wrData(item),
        .rdSlot(pendSlot_q),
        .rdData(bufRd)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    // joint ops move at most half a file of doubles (32 elements)
    assign cntEff = (reqOp >= single_to_double_convert_op && reqCount > `VM_JOINT_MAX)
        ? `VM_JOINT_MAX : reqCount;

    // next state of sequencer, counters and destination stage
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        elem_d = elem_q;
        out_d = out_q;
        wcnt_d = wcnt_q;
        masked_d = masked_q;
        bcast_d = bcast_q;
        gen_d = gen_q;
        stride_d = stride_q;
        ack_d = 1'b0;
        done_d = 1'b0;
        pend_d = 1'b0;
        pendIdx_d = pendIdx_q;
        pendSlot_d = pendSlot_q;
        addValid_d = 1'b0;
        addData_d = addData_q;
        dstWe_d = pend_q;
        dstIdx_d = pend_q ? pendIdx_q : dstIdx_q;
        dstData_d = pend_q ? bufRd : dstData_q;
        case (state_q)
            ST_IDLE: begin
                if (reqValid && ctrl_q[`VM_CTRL_ENABLE]) begin
                    state_d = ST_ACK;
                    ack_d = 1'b1;
                    op_d = reqOp;
                    cnt_d = cntEff;
                    masked_d = reqMasked;
                    bcast_d = reqBroadcast;
                    gen_d = thirdRegData;
                    stride_d = reqStrideOne ? 36'h1 : {18'h0, thirdRegData[17:0]};
                    elem_d = 7'h0;
                    out_d = 7'h0;
                    wcnt_d = 7'h0;
                end
            end
            ST_ACK: state_d = ST_RUN;
            ST_RUN: begin
                if (issue) begin
                    elem_d = elem_q + 7'h1;
                    gen_d = gen_q + stride_q;
                    if (op_q == sign_count_op) begin
                        addValid_d = 1'b1;
                        addData_d = srcData;
                    end
                    if (sel) begin
                        pend_d = 1'b1;
                        pendSlot_d = elem_q[4:0];
                        pendIdx_d = isCompress ? out_q[5:0] : elem_q[5:0];
                        out_d = out_q + 7'h1;
                        wcnt_d = wcnt_q + 7'h1;
                    end
                    if (lastElem) begin
                        state_d = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                state_d = ST_IDLE;
                done_d = 1'b1;
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = state_d != ST_IDLE;
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            op_q <= move_vector_op;
            cnt_q <= 7'h0;
            elem_q <= 7'h0;
            out_q <= 7'h0;
            wcnt_q <= 7'h0;
            masked_q <= 1'b0;
            bcast_q <= 1'b0;
            gen_q <= 36'h0;
            stride_q <= 36'h0;
            ack_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            pend_q <= 1'b0;
            pendIdx_q <= 6'h0;
            pendSlot_q <= 5'h0;
            addValid_q <= 1'b0;
            addData_q <= 72'h0;
            dstWe_q <= 1'b0;
            dstIdx_q <= 6'h0;
            dstData_q <= 72'h0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            elem_q <= elem_d;
            out_q <= out_d;
            wcnt_q <= wcnt_d;
            masked_q <= masked_d;
            bcast_q <= bcast_d;
            gen_q <= gen_d;
            stride_q <= stride_d;
            ack_q <= ack_d;
            done_q <= done_d;
            busy_q <= busy_d;
            pend_q <= pend_d;
            pendIdx_q <= pendIdx_d;
            pendSlot_q <= pendSlot_d;
            addValid_q <= addValid_d;
            addData_q <= addData_d;
            dstWe_q <= dstWe_d;
            dstIdx_q <= dstIdx_d;
            dstData_q <= dstData_d;
        end
    end

    assign reqAck = ack_q;
    assign done = done_q;
    assign busy = busy_q;
    assign srcRdIdx = elem_q[5:0];
    assign dstWe = dstWe_q;
    assign dstIdx = dstIdx_q;
    assign dstData = dstData_q;
    assign addValid = addValid_q;
    assign addData = addData_q;

    ////////////////////////////////////////////////////////////////////////
    // register slave; address and data are taken together

    logic awready_q, awready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        if (awready_q) begin
            bvalid_d = 1'b1;
            bresp_d = `VM_RESP_SLVERR;
            if (awaddr == `VM_CTRL_OFF) begin
                bresp_d = `VM_RESP_OKAY;
                if (wstrb[0]) begin
                    ctrl_d = wdata[1:0];
                end
            end
        end
        arready_d = arvalid && !arready_q && !rvalid_q;
        rvalid_d = rvalid_q && !rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = `VM_RESP_OKAY;
            case (araddr)
                `VM_CTRL_OFF: rdata_d = {30'h0, ctrl_q};
                `VM_STATUS_OFF: rdata_d = {17'h0, elem_q, 5'h0, state_q, busy_q};
                `VM_WCOUNT_OFF: rdata_d = {25'h0, wcnt_q};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = `VM_RESP_SLVERR;
                end
            endcase
        end
    end

    // register slave flops
    always_ff @(posedge clk) begin
        if (reset) begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `VM_RESP_OKAY;
            ctrl_q <= `VM_CTRL_RESET;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `VM_RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            awready_q <= awready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            ctrl_q <= ctrl_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign awready = awready_q;
    assign wready = awready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_ackThenRun;
        reqAck && state_q == ST_ACK ##1 state_q == ST_RUN;
    endsequence
    sequence s_bufThenFile;
        pend_q ##1 dstWe_q;
    endsequence

    property p_ackFirst;
        @(posedge clk) disable iff (reset)
        (state_q == ST_IDLE && reqValid && ctrl_q[0]) |=> s_ackThenRun;
    endproperty
    a_ackFirst: assert property (p_ackFirst) else $error("no ack before run");

    property p_idleQuiet;
        @(posedge clk) disable iff (reset)
        (state_q == ST_IDLE && !pend_q) |=> !dstWe_q;
    endproperty
    a_idleQuiet: assert property (p_idleQuiet) else $error("write while idle");

    property p_suspendHold;
        @(posedge clk) disable iff (reset)
        (state_q == ST_RUN && suspend) |=> $stable(elem_q) && !pend_q;
    endproperty
    a_suspendHold: assert property (p_suspendHold) else $error("moved while held");

    property p_stepOne;
        @(posedge clk) disable iff (reset)
        issue |=> elem_q == $past(elem_q) + 7'h1;
    endproperty
    a_stepOne: assert property (p_stepOne) else $error("element skipped");

    property p_viaBuffer;
        @(posedge clk) disable iff (reset)
        bufWe |=> s_bufThenFile;
    endproperty
    a_viaBuffer: assert property (p_viaBuffer) else $error("buffer bypassed");

    property p_compressPack;
        @(posedge clk) disable iff (reset)
        (bufWe && isCompress) |-> ##2 (dstWe_q && dstIdx_q == $past(out_q[5:0], 2));
    endproperty
    a_compressPack: assert property (p_compressPack) else $error("bad pack");

    property p_distPlace;
        @(posedge clk) disable iff (reset)
        (bufWe && isDist) |-> ##2 (dstWe_q && dstIdx_q == $past(elem_q[5:0], 2));
    endproperty
    a_distPlace: assert property (p_distPlace) else $error("bad place");

    property p_maskGate;
        @(posedge clk) disable iff (reset)
        (issue && masked_q && !isCompress && !maskBit) |=> !pend_q;
    endproperty
    a_maskGate: assert property (p_maskGate) else $error("masked element written");

    property p_genStride;
        @(posedge clk) disable iff (reset)
        (issue && op_q == index_generate_op) |=> gen_q == $past(gen_q) + stride_q;
    endproperty
    a_genStride: assert property (p_genStride) else $error("bad index step");

    property p_bcastCopy;
        @(posedge clk) disable iff (reset)
        (bufWe && bcast_q && op_q == move_vector_op)
            |-> ##2 dstData_q[35:0] == $past(thirdRegData, 2);
    endproperty
    a_bcastCopy: assert property (p_bcastCopy) else $error("bad broadcast");
endmodule // vector_move_pipeline
`default_nettype wire

// *** vector_move_defines.svh ***
// constants for the vector move pipeline
`ifndef VECTOR_MOVE_DEFINES_SVH
`define VECTOR_MOVE_DEFINES_SVH

`define VM_BUF_DEPTH 32
`define VM_MAX_COUNT 64
`define VM_JOINT_MAX 7'h20
`define VM_WORD_W 36
`define VM_ELEM_W 72
`define VM_CTRL_OFF 8'h00
`define VM_STATUS_OFF 8'h04
`define VM_WCOUNT_OFF 8'h08
`define VM_CTRL_ENABLE 0
`define VM_CTRL_POLARITY 1
`define VM_CTRL_RESET 2'h3
`define VM_RESP_OKAY 2'h0
`define VM_RESP_SLVERR 2'h2

`endif

// *** vector_move_pkg.sv ***
// types shared by the vector move pipeline
`default_nettype none
package vector_move_pkg;
    typedef enum logic [3:0] {
        move_vector_op = 4'h0,
        double_move_vector_op = 4'h1,
        move_negated_op = 4'h2,
        double_move_negated_op = 4'h3,
        compress_op = 4'h4,
        double_compress_op = 4'h5,
        distribute_op = 4'h6,
        double_distribute_op = 4'h7,
        index_generate_op = 4'h8,
        population_parity_op = 4'h9,
        single_to_double_convert_op = 4'ha,
        double_to_single_convert_op = 4'hb,
        sign_count_op = 4'hc
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK = 2'b01,
        ST_RUN = 2'b10,
        ST_DRAIN = 2'b11
    } state_t;
endpackage
`default_nettype wire

// *** move_buffer.sv ***
// move buffer: flop storage, one write and one combinational read port
`timescale 1ns/10ps
`default_nettype none
`include "vector_move_defines.svh"
module move_buffer (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [4:0] wrSlot,
    input wire logic [`VM_ELEM_W-1:0] wrData,
    input wire logic [4:0] rdSlot,
    output logic [`VM_ELEM_W-1:0] rdData
);
    logic [`VM_ELEM_W-1:0] entry_q [`VM_BUF_DEPTH];
    logic [`VM_ELEM_W-1:0] entry_d [`VM_BUF_DEPTH];

    // one entry per slot, each two words wide
    for (genvar i = 0; i < `VM_BUF_DEPTH; i++) begin : g_entry
        always_comb begin
            entry_d[i] = entry_q[i];
            if (wrEn && wrSlot == 5'(i)) begin
                entry_d[i] = wrData;
            end
        end
        always_ff @(posedge clk) begin
            if (reset) begin
                entry_q[i] <= '0;
            end else begin
                entry_q[i] <= entry_d[i];
            end
        end
    end

    assign rdData = entry_q[rdSlot];
endmodule // move_buffer
`default_nettype wire

// *** vm_far_side.sv ***
// far side model: source and shadow vector files plus the add pipe's sign counter
`timescale 1ns/10ps
`default_nettype none
module vm_far_side (
    input wire logic [31:0] salt,
    input wire logic countMode,
    input wire logic [5:0] srcRdIdx,
    output logic [71:0] srcData,
    output logic [71:0] shadowData
);
    ////////////////////////////////////////////////////////////////////////////////
    // leading sign count from bit 70 downwards, bit 71 being the msb
    function automatic logic [6:0] signCnt(input logic [71:0] v);
        signCnt = 7'h00;
        for (int b = 70; b >= 0 && v[b] == v[71]; b--) signCnt++;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // salt changes per op so a stale element never passes for a fresh one
    assign srcData = {salt, 4'h0, salt ^ {26'h0, srcRdIdx}, 4'h0};
    // shadow results are ready at the issue index; conversion stands in as inversion
    assign shadowData = countMode ? {65'h0, signCnt(srcData)} : ~srcData;
endmodule // vm_far_side
`default_nettype wire

// *** vector_move_pipeline_tb.sv ***
// self-checking bench for the vector move pipeline
`timescale 1ns/10ps
`default_nettype none
module vector_move_pipeline_tb;
    import vector_move_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, salt = 32'h0, rs = 32'he01e70ce;
    logic reqValid = 1'h0, reqMasked = 1'h0, reqBroadcast = 1'h0, reqStrideOne = 1'h0;
    logic suspend = 1'h0, countMode = 1'h0;
    op_t reqOp = move_vector_op;
    logic [6:0] reqCount = 7'h01;
    logic [35:0] thirdRegData = 36'h0;
    logic [63:0] maskBits = 64'h0;
    logic awready, wready, bvalid, arready, rvalid, reqAck, busy, done, dstWe, addValid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] srcRdIdx, dstIdx;
    logic [71:0] srcData, shadowData, dstData, addData;
    logic [77:0] dq[$];
    logic [71:0] aq[$];
    int errTotal = 0, checkCount = 0, cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    vector_move_pipeline vector_move_pipeline_inst (.clk, .reset, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .reqValid, .reqOp, .reqCount, .reqMasked,
        .reqBroadcast, .reqStrideOne, .thirdRegData, .maskBits, .suspend, .srcData, .shadowData,
        .reqAck, .busy, .done, .srcRdIdx, .dstWe, .dstIdx, .dstData, .addValid, .addData);
    vm_far_side vm_far_side_inst (.salt, .countMode, .srcRdIdx, .srcData, .shadowData);

    // 100 MHz clock
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // own copy of the sign count so expectations never lean on the model
    function automatic logic [6:0] signCnt(input logic [71:0] v);
        signCnt = 7'h00;
        for (int b = 70; b >= 0 && v[b] == v[71]; b--) signCnt++;
    endfunction

    task automatic chk(input logic [77:0] seen, input logic [77:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic reportAndStop();
        $display("checks %0d errors %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard: about ten times the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            reportAndStop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write: address and data offered together, each dropped once taken
    task automatic axiWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        v = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // notes every expected destination write, then runs one instruction
    task automatic runOp(input op_t op, input int rc, input logic m, input logic bc,
                         input logic so, input logic sus, input logic pol);
        logic [71:0] e, v;
        logic [35:0] g, stride;
        logic [31:0] s, d;
        logic [63:0] mask;
        logic [1:0] r;
        logic sel;
        int n, j;
        s = rnd();
        g = {rnd(), 4'ha};
        mask = {rnd(), rnd()};
        stride = so ? 36'h1 : {18'h0, g[17:0]};
        n = (op >= single_to_double_convert_op && rc > 32) ? 32 : rc;
        j = 0;
        for (int k = 0; k < n; k++) begin
            e = {s, 4'h0, s ^ k[31:0], 4'h0};
            v = bc ? {g, g} : e;
            sel = 1'h1;
            case (op)
                move_negated_op, double_move_negated_op: v = ~v;
                compress_op, double_compress_op: sel = (mask[k] == pol);
                distribute_op, double_distribute_op: sel = mask[k];
                index_generate_op: v = {36'h0, 36'(g + stride * 36'(k))};
                population_parity_op: v = {71'h0, ^e[35:0]};
                single_to_double_convert_op: v = ~e;
                double_to_single_convert_op: v = {36'h0, ~e[35:0]};
                sign_count_op: begin
                    v = {65'h0, signCnt(e)};
                    aq.push_back(e);
                end
                default: ;
            endcase
            if (op <= double_distribute_op && !op[0]) v = {36'h0, v[35:0]};
            if (m) sel = mask[k];
            if (sel) dq.push_back({(op == compress_op || op == double_compress_op) ?
                                   6'(j) : 6'(k), v});
            if (sel) j++;
        end
        @(posedge clk);
        reqOp <= op;
        reqCount <= 7'(rc);
        reqMasked <= m;
        reqBroadcast <= bc;
        reqStrideOne <= so;
        thirdRegData <= g;
        maskBits <= mask;
        salt <= s;
        countMode <= (op == sign_count_op);
        reqValid <= 1'h1;
        do @(posedge clk); while (reqAck !== 1'h1);
        reqValid <= 1'h0;
        chk(busy, 1'h1);
        // an eight-cycle conflict hold in mid-run; elements must neither repeat nor drop
        if (sus) begin
            repeat (2) @(posedge clk);
            suspend <= 1'h1;
            repeat (8) @(posedge clk);
            suspend <= 1'h0;
        end
        while (done !== 1'h1) @(posedge clk);
        chk(busy, 1'h0);
        repeat (2) @(posedge clk);
        chk(dq.size(), 0);
        chk(aq.size(), 0);
        axiRd(8'h08, d, r);
        chk({r, d}, {2'h0, j[31:0]});
        // element counter must stop exactly at the count, suspension or not
        axiRd(8'h04, d, r);
        chk({r, d}, {2'h0, 17'h0, 7'(n), 8'h00});
    endtask

    // each result taken off the oldest note as it appears
    always @(posedge clk) begin
        if (!reset && dstWe === 1'h1) begin
            chk({dstIdx, dstData}, dq.size() ? dq.pop_front() : 'x);
        end
        if (!reset && addValid === 1'h1) chk(addData, aq.size() ? aq.pop_front() : 'x);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: register checks, every op three times, then a disabled request
    initial begin
        logic [31:0] d, x;
        logic [1:0] r;
        logic ack;
        op_t op;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        axiRd(8'h00, d, r);
        chk({r, d}, {2'h0, 32'h3});
        axiRd(8'h0c, d, r);
        chk({r, d}, {2'h2, 32'h0});
        axiWr(8'h04, 32'h1, r);
        chk(r, 2'h2);
        for (int i = 0; i < 39; i++) begin
            x = rnd();
            op = op_t'(i % 13);
            axiWr(8'h00, {30'h0, x[4], 1'h1}, r);
            chk(r, 2'h0);
            runOp(op, (i < 13) ? 64 : (i < 26) ? 1 : int'(x[10:5]) + 1,
                  op <= double_move_negated_op && x[0], op <= double_move_vector_op && x[1],
                  x[2], x[3] && i < 13, x[4]);
        end
        axiWr(8'h00, 32'h0, r);
        ack = 1'h0;
        @(posedge clk);
        reqValid <= 1'h1;
        repeat (20) begin
            @(posedge clk);
            if (reqAck === 1'h1) ack = 1'h1;
        end
        reqValid <= 1'h0;
        chk(ack, 1'h0);
        reportAndStop();
    end
endmodule // vector_move_pipeline_tb
`default_nettype wire
